/* File: core/dcp_params.svh */
// Constants for the converter control pin block: word layout, commands,
// control fields and reset values. Definitions only.
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH

// Serial word layout
`define DCP_WORD_W 24
`define DCP_CMD_MSB 19
`define DCP_CMD_LSB 16
`define DCP_DATA_MSB 15
`define DCP_DATA_LSB 0
`define DCP_CODE_W 16

// Commands carried in the word
`define DCP_CMD_NOP 4'h0
`define DCP_CMD_WR_IN 4'h1
`define DCP_CMD_UPD 4'h2
`define DCP_CMD_WR_UPD 4'h3
`define DCP_CMD_WR_CTRL 4'h4
`define DCP_CMD_SW_RST 4'hf

// Control register fields
`define DCP_CTRL_W 3
`define DCP_CTRL_CLR_MSB 1
`define DCP_CTRL_CLR_LSB 0
`define DCP_CTRL_BUF_EN 2

// Clear code selections and codes
`define DCP_CLR_ZERO 2'h0
`define DCP_CLR_MID 2'h1
`define DCP_CLR_FULL 2'h2
`define DCP_CODE_ZERO 16'h0000
`define DCP_CODE_MID 16'h8000
`define DCP_CODE_FULL 16'hffff

// Reset values
`define DCP_CTRL_RST 3'h0
`define DCP_WORD_RST 24'h000000
// Synchroniser idle levels: strobe, clear, reset, sclk, frame high; faults low
`define DCP_SYNC_RST 8'h1f

`endif

/* File: core/dcp_pkg.sv */
// Types shared by the converter control pin block.
// Assumes dcp_params.svh is compiled alongside.
package dcp_pkg;

    // Frame tracking states, one-hot
    typedef enum logic [2:0] {
        DCP_IDLE = 3'b001,
        DCP_SHIFT = 3'b010,
        DCP_LATCH = 3'b100
    } dcp_state_t;

endpackage

/* File: core/dcp_ctrl.sv */
// Converter control pin logic: framed serial input, load strobe, clear,
// hardware reset and alert output.
// Assumes every pin input is asynchronous to core_clk_i and slower than
// a quarter of its rate; pin pull-ups are modelled by the pad ring.
`timescale 1ns/100ps
`include "dcp_params.svh"

////////////////////////////////////////////////////////////////////////////////
module dcp_ctrl
    import dcp_pkg::*;
#(
    parameter int WORD_W = `DCP_WORD_W
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Serial link pins
    input wire logic frame_sel_n_i,
    input wire logic sclk_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    // Control pins
    input wire logic output_load_strobe_n_i,
    input wire logic clear_n_i,
    input wire logic hw_reset_n_i,
    // Fault flags from analog monitors
    input wire logic over_temp_i,
    input wire logic out_short_i,
    input wire logic brownout_i,
    // Status and converter outputs
    output logic alert_n_o,
    output logic [`DCP_CODE_W-1:0] conv_code_o,
    output logic out_clamp_o,
    output logic buf_pd_o
);

    // Elaboration check on word width
    if (WORD_W < `DCP_CMD_MSB + 1) begin : g_bad_width
        $error("WORD_W too small for command field");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    function automatic logic [`DCP_CODE_W-1:0] clr_code(input logic [1:0] sel);
        case (sel)
            `DCP_CLR_MID: clr_code = `DCP_CODE_MID;
            `DCP_CLR_FULL: clr_code = `DCP_CODE_FULL;
            default: clr_code = `DCP_CODE_ZERO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage 1, stage 2, and a history stage for edges
    logic [7:0] s1_r, s2_r, s3_r;
    logic [7:0] s1_nxt, s2_nxt, s3_nxt;
    logic [7:0] pins;

    // Idle levels are high for strobe, clear and reset pins
    localparam logic [7:0] SYNC_RST = `DCP_SYNC_RST;

    assign pins = {brownout_i, out_short_i, over_temp_i, hw_reset_n_i,
                   clear_n_i, output_load_strobe_n_i, sclk_i, frame_sel_n_i};

    always_comb begin
        s1_nxt = ce_i ? pins : s1_r;
        s2_nxt = ce_i ? s1_r : s2_r;
        s3_nxt = ce_i ? s2_r : s3_r;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // Serial data is sampled together with the clock edges
    logic sin_s1_r, sin_s2_r;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sin_s1_r <= 1'b0;
            sin_s2_r <= 1'b0;
        end else if (ce_i) begin
            sin_s1_r <= serial_in_i;
            sin_s2_r <= sin_s1_r;
        end
    end

    // Decoded levels and edges
    logic frame_lo, sclk_fall, sclk_rise, frame_rise;
    logic strobe_lo, strobe_fall, clr_fall, hwrst_lo, fault;

    assign frame_lo = ~s2_r[0];
    assign frame_rise = s2_r[0] & ~s3_r[0]; // Frame select returns high
    assign sclk_fall = fell(s3_r[1], s2_r[1]);
    assign sclk_rise = s2_r[1] & ~s3_r[1];
    assign strobe_lo = ~s2_r[2];
    assign strobe_fall = fell(s3_r[2], s2_r[2]);
    assign clr_fall = fell(s3_r[3], s2_r[3]);
    assign hwrst_lo = ~s2_r[4];
    assign fault = |s2_r[7:5];

    ////////////////////////////////////////////////////////////////////////////
    // Frame state machine and shift register
    dcp_state_t state_r, state_nxt;
    logic [WORD_W-1:0] sh_r, sh_nxt;
    logic sout_r, sout_nxt;

    always_comb begin
        state_nxt = state_r;
        sh_nxt = sh_r;
        sout_nxt = sout_r;
        if (ce_i) begin
            case (state_r)
                DCP_IDLE: begin
                    if (frame_lo) begin
                        state_nxt = DCP_SHIFT;
                    end
                end
                DCP_SHIFT: begin
                    if (frame_rise) begin
                        state_nxt = DCP_LATCH;
                    end
                end
                DCP_LATCH: begin
                    state_nxt = DCP_IDLE;
                end
                default: begin
                    state_nxt = DCP_IDLE;
                end
            endcase
            // Accept bits only inside a frame
            if (frame_lo && sclk_fall) begin
                sh_nxt = {sh_r[WORD_W-2:0], sin_s2_r};
            end
            // Present the next outgoing bit on the rising edge
            if (frame_lo && sclk_rise) begin
                sout_nxt = sh_r[WORD_W-1];
            end
            if (hwrst_lo) begin
                state_nxt = DCP_IDLE;
                sh_nxt = WORD_W'(`DCP_WORD_RST);
                sout_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= DCP_IDLE;
            sh_r <= '0;
            sout_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sh_r <= sh_nxt;
            sout_r <= sout_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode, input/converter registers, control and alert
    logic [3:0] cmd;
    logic [`DCP_CODE_W-1:0] wdata;
    logic latch;

    assign latch = ce_i && (state_r == DCP_LATCH) && !hwrst_lo; // One cycle after frame end
    assign cmd = sh_r[`DCP_CMD_MSB:`DCP_CMD_LSB];
    assign wdata = sh_r[`DCP_DATA_MSB:`DCP_DATA_LSB];

    logic [`DCP_CODE_W-1:0] in_r, in_nxt, dac_r, dac_nxt;
    logic [`DCP_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic pend_r, pend_nxt, rstf_r, rstf_nxt;
    logic alert_r, alert_nxt, clamp_r, clamp_nxt, pd_r, pd_nxt;

    always_comb begin
        in_nxt = in_r;
        dac_nxt = dac_r;
        ctrl_nxt = ctrl_r;
        pend_nxt = pend_r;
        rstf_nxt = rstf_r;
        clamp_nxt = clamp_r;
        pd_nxt = pd_r;
        alert_nxt = alert_r;
        if (ce_i) begin
            // Strobe falling edge releases a pending value
            if (strobe_fall && pend_r) begin
                dac_nxt = in_r;
                pend_nxt = 1'b0;
            end
            if (latch) begin
                case (cmd)
                    `DCP_CMD_WR_IN: begin
                        in_nxt = wdata;
                        if (strobe_lo) begin
                            dac_nxt = wdata;
                            pend_nxt = 1'b0;
                        end else begin
                            pend_nxt = 1'b1;
                        end
                    end
                    `DCP_CMD_UPD: begin
                        dac_nxt = in_r;
                        pend_nxt = 1'b0;
                    end
                    `DCP_CMD_WR_UPD: begin
                        in_nxt = wdata;
                        dac_nxt = wdata;
                        pend_nxt = 1'b0;
                    end
                    `DCP_CMD_WR_CTRL: begin
                        ctrl_nxt = wdata[`DCP_CTRL_W-1:0];
                        rstf_nxt = 1'b0;
                        pd_nxt = ~wdata[`DCP_CTRL_BUF_EN];
                        clamp_nxt = ~wdata[`DCP_CTRL_BUF_EN];
                    end
                    `DCP_CMD_SW_RST: begin
                        in_nxt = `DCP_CODE_ZERO;
                        dac_nxt = `DCP_CODE_ZERO;
                        ctrl_nxt = `DCP_CTRL_RST;
                        pend_nxt = 1'b0;
                        rstf_nxt = 1'b1;
                        clamp_nxt = 1'b1;
                        pd_nxt = 1'b1;
                    end
                    default: begin
                        in_nxt = in_r;
                    end
                endcase
            end
            // Clear wins over any load in the same cycle
            if (clr_fall) begin
                dac_nxt = clr_code(ctrl_r[`DCP_CTRL_CLR_MSB:`DCP_CTRL_CLR_LSB]);
            end
            // Hardware reset held low forces defaults
            if (hwrst_lo) begin
                in_nxt = `DCP_CODE_ZERO;
                dac_nxt = `DCP_CODE_ZERO;
                ctrl_nxt = `DCP_CTRL_RST;
                pend_nxt = 1'b0;
                rstf_nxt = 1'b1;
                clamp_nxt = 1'b1;
                pd_nxt = 1'b1;
            end
            alert_nxt = ~(fault | rstf_nxt);
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            in_r <= `DCP_CODE_ZERO;
            dac_r <= `DCP_CODE_ZERO;
            ctrl_r <= `DCP_CTRL_RST;
            pend_r <= 1'b0;
            rstf_r <= 1'b1;
            alert_r <= 1'b0;
            clamp_r <= 1'b1;
            pd_r <= 1'b1;
        end else begin
            in_r <= in_nxt;
            dac_r <= dac_nxt;
            ctrl_r <= ctrl_nxt;
            pend_r <= pend_nxt;
            rstf_r <= rstf_nxt;
            alert_r <= alert_nxt;
            clamp_r <= clamp_nxt;
            pd_r <= pd_nxt;
        end
    end

    // Outputs straight from flops
    assign serial_out_o = sout_r;
    assign alert_n_o = alert_r;
    assign conv_code_o = dac_r;
    assign out_clamp_o = clamp_r;
    assign buf_pd_o = pd_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    alert_fault_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i && fault |=> !alert_n_o) else $error("alert not low on fault");

    alert_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i && hwrst_lo ##1 (!ce_i || !latch || cmd != `DCP_CMD_WR_CTRL)[*2] |-> !alert_n_o)
        else $error("alert released without control write");

    clear_load_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i && clr_fall && !hwrst_lo |=> conv_code_o == clr_code($past(ctrl_r[`DCP_CTRL_CLR_MSB:`DCP_CTRL_CLR_LSB])))
        else $error("clear code not loaded");

    hw_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i && hwrst_lo |=> out_clamp_o && buf_pd_o && conv_code_o == `DCP_CODE_ZERO)
        else $error("hardware reset defaults missing");

    strobe_low_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        latch && cmd == `DCP_CMD_WR_IN && strobe_lo && !clr_fall |=> conv_code_o == $past(wdata))
        else $error("write with strobe low not transferred");

    strobe_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        latch && cmd == `DCP_CMD_WR_IN && !strobe_lo && !clr_fall && !strobe_fall
        |=> conv_code_o == $past(conv_code_o) && pend_r) else $error("held write leaked");

    sout_shift_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i && frame_lo && sclk_rise && !hwrst_lo |=> serial_out_o == $past(sh_r[WORD_W-1]))
        else $error("serial out not updated on rising edge");

    shift_in_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i && frame_lo && sclk_fall && !hwrst_lo |=> sh_r[0] == $past(sin_s2_r))
        else $error("bit not shifted on falling edge");

    frame_idle_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i && !frame_lo && !hwrst_lo |=> $stable(sh_r)) else $error("shift outside frame");

    frame_latch_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        latch && cmd == `DCP_CMD_WR_CTRL |=> !rstf_r ##1 (alert_n_o == !$past(fault)))
        else $error("control write not acted on at frame end");

endmodule

/* File: verification/dcp_host_model.sv */
// Host side of the framed serial link: frame select, serial clock, data.
// Assumes the core clock paces the link; 4 core cycles per serial level.
`timescale 1ns/100ps

module dcp_host_model (
    // Core clock used for pacing only
    input wire logic core_clk_i,
    // Link pins
    input wire logic serial_out_i,
    output logic frame_sel_n_o,
    output logic sclk_o,
    output logic serial_in_o
);
    // Bits seen on serial_out at each falling serial clock edge
    logic [23:0] cap_r;

    // Link idles with frame high and serial clock parked high
    initial begin
        frame_sel_n_o = 1'b1;
        sclk_o = 1'b1;
        serial_in_o = 1'b0;
        cap_r = 24'h000000;
    end

    // One serial clock level: 40 ns, a 12.5 MHz link
    task automatic half();
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask

    // Sends one word MSB first; frame held low for the whole word
    task automatic send_word(input logic [23:0] w);
        @(posedge core_clk_i);
        #1;
        frame_sel_n_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serial_in_o = w[i];
            half();
            sclk_o = 1'b0;
            cap_r = {cap_r[22:0], serial_out_i};
            half();
            sclk_o = 1'b1;
        end
        half();
        frame_sel_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
        half();
    endtask

    // Clock and data toggling with frame high, which the device must ignore
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in_o = ~serial_in_o;
            sclk_o = 1'b0;
            half();
            sclk_o = 1'b1;
            half();
        end
    endtask
endmodule

/* File: verification/test_dcp_ctrl.sv */
// Self-checking bench for the converter control pin block.
// Assumes dcp_params.svh on the include path and the host model beside it.
`timescale 1ns/100ps
`include "dcp_params.svh"

module test_dcp_ctrl;
    import dcp_pkg::*;

    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic frame_sel_n, sclk, serial_in, serial_out;
    logic load_n = 1'b1;
    logic clear_n = 1'b1;
    logic hw_n = 1'b1;
    logic [2:0] fault = 3'h0;
    logic alert_n, clamp, buf_pd;
    logic [15:0] code;
    int err_count = 0;
    int n_tests = 0;

    // 100 MHz core clock
    always #5 core_clk_i = ~core_clk_i;

    dcp_ctrl dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .frame_sel_n_i(frame_sel_n), .sclk_i(sclk), .serial_in_i(serial_in),
        .serial_out_o(serial_out), .output_load_strobe_n_i(load_n),
        .clear_n_i(clear_n), .hw_reset_n_i(hw_n), .over_temp_i(fault[0]),
        .out_short_i(fault[1]), .brownout_i(fault[2]), .alert_n_o(alert_n),
        .conv_code_o(code), .out_clamp_o(clamp), .buf_pd_o(buf_pd)
    );

    dcp_host_model host (
        .core_clk_i(core_clk_i), .serial_out_i(serial_out),
        .frame_sel_n_o(frame_sel_n), .sclk_o(sclk), .serial_in_o(serial_in)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Pin changes need a few cycles through the sync chain
    task automatic settle();
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wr(input logic [3:0] cmd, input logic [15:0] data);
        host.send_word({4'h0, cmd, data});
        settle();
    endtask

    // Defaults: code zero, clamp on, buffer off, alert low
    task automatic chk_defaults();
        check("code", {8'h00, code}, 24'h0);
        check("clamp", {23'h0, clamp}, 24'h1);
        check("buf_pd", {23'h0, buf_pd}, 24'h1);
        check("alert", {23'h0, alert_n}, 24'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_ctrl();
        chk_defaults();
        wr(`DCP_CMD_WR_CTRL, 16'h0005);
        check("alert", {23'h0, alert_n}, 24'h1);
        check("clamp", {23'h0, clamp}, 24'h0);
    endtask

    task automatic t_load();
        load_n = 1'b0;
        wr(`DCP_CMD_WR_IN, 16'h1234);
        check("code", {8'h00, code}, 24'h1234);
        load_n = 1'b1;
        wr(`DCP_CMD_WR_IN, 16'habcd);
        check("code", {8'h00, code}, 24'h1234);
        load_n = 1'b0;
        settle();
        check("code", {8'h00, code}, 24'habcd);
    endtask

    task automatic t_clear();
        logic [15:0] exp [4];
        exp = '{`DCP_CODE_ZERO, `DCP_CODE_MID, `DCP_CODE_FULL, `DCP_CODE_ZERO};
        for (int s = 0; s < 4; s++) begin
            wr(`DCP_CMD_WR_CTRL, {14'h1, 2'(s)});
            wr(`DCP_CMD_WR_IN, 16'h5a5a);
            clear_n = 1'b0;
            settle();
            check("clear code", {8'h00, code}, {8'h00, exp[s]});
            clear_n = 1'b1;
            settle();
        end
    endtask

    task automatic t_faults();
        for (int f = 0; f < 3; f++) begin
            fault = 3'(1 << f);
            settle();
            check("alert", {23'h0, alert_n}, 24'h0);
            fault = 3'h0;
            settle();
            check("alert", {23'h0, alert_n}, 24'h1);
        end
    endtask

    // Update, write-and-update and software reset commands
    task automatic t_cmds();
        load_n = 1'b1;
        wr(`DCP_CMD_WR_IN, 16'h2222);
        check("code", {8'h00, code}, 24'h0);
        wr(`DCP_CMD_UPD, 16'h0000);
        check("code", {8'h00, code}, 24'h2222);
        wr(`DCP_CMD_WR_UPD, 16'h3333);
        check("code", {8'h00, code}, 24'h3333);
        wr(`DCP_CMD_SW_RST, 16'h0000);
        chk_defaults();
        load_n = 1'b0;
        settle();
        check("code", {8'h00, code}, 24'h0);
    endtask

    // Word shifted in comes back out; idle noise must not disturb it
    task automatic t_serial_out();
        host.send_word(24'hc03a5c);
        host.noise(6);
        check("code", {8'h00, code}, 24'h0000);
        host.send_word(24'h000000);
        check("serial out", {1'b0, host.cap_r[22:0]}, 24'h403a5c);
        check("serial out", {1'b0, host.cap_r[22:0]}, 24'h403a5c);
    endtask

    task automatic t_hw_reset();
        wr(`DCP_CMD_WR_IN, 16'h7777);
        hw_n = 1'b0;
        settle();
        chk_defaults();
        hw_n = 1'b1;
        settle();
        chk_defaults();
        wr(`DCP_CMD_WR_CTRL, 16'h0004);
        check("alert", {23'h0, alert_n}, 24'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and run control
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog: about 20 frames of 2 us each fit well inside this span
    initial begin
        #300us;
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        t_ctrl();
        t_load();
        t_clear();
        t_faults();
        t_cmds();
        t_hw_reset();
        t_serial_out();
        print_verdict();
    end
endmodule
